// [bench/sli_modem_model.sv]
module sli_modem_model (
   input wire logic clock,
   input wire logic [1:0] rtsOut,
   input wire logic holdOff,
   output logic [1:0] ctsIn
);
   timeunit 1ns;
   timeprecision 100ps;
   initial ctsIn = 2'b00;
   // Answers a cycle late; holdOff withholds clear-to-send
   always @(posedge clock) ctsIn <= holdOff ? 2'b00 : rtsOut;
endmodule

// [bench/tb_sli_indicators.sv]
`include "sli_consts.svh"
module tb_sli_indicators;
   timeunit 1ns;
   timeprecision 100ps;
   import sli_pkg::*;
   logic clock = 0, rst = 1, wr = 0, rd = 0, cpuBusy = 0, periphReq = 0, holdOff = 0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000, rdata, got, hi;
   sli_chev_s [1:0] ev = '0;
   sli_chst_s [1:0] st;
   logic [1:0] cts, txAllow, rts;
   logic periphSel, rateError, errorLamp, accessLamp;
   int n_fail = 0, n_compared = 0;
   always #2.5 clock = ~clock;
   sli_indicators #(.BLINK_CYCLES(4)) uut (.clock(clock), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .chEvent(ev), .cpuBusy(cpuBusy),
      .ctsIn(cts), .periphReq(periphReq), .chStat(st), .txAllow(txAllow), .rtsOut(rts),
      .periphSel(periphSel), .rateError(rateError), .errorLamp(errorLamp),
      .accessLamp(accessLamp));
   sli_modem_model far (.clock(clock), .rtsOut(rts), .holdOff(holdOff), .ctsIn(cts));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task waitc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task wrReg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clock);
      wr <= 0;
      #1;
   endtask
   task rdReg(input logic [3:0] a, output logic [15:0] q);
      @(posedge clock);
      addr <= a;
      rd <= 1;
      @(posedge clock);
      rd <= 0;
      #1;
      q = rdata;
   endtask
   task pulse(input int c, input sli_chev_s m);
      @(posedge clock);
      ev[c] <= m;
      @(posedge clock);
      ev[c] <= '0;
      #1;
   endtask
   task final_report;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clock);
      n_fail++;
      final_report;
   end
   initial begin
      repeat (20) @(posedge clock);
      rst <= 0;
      rdReg(`SLI_ADDR_LAMPS, got); chk(got, 16'h0000);
      for (int c = 0; c < 2; c++) for (int f = 4; f < 7; f++) begin
         pulse(c, 11'(1 << f)); chk(st[c].serialErr, 1);
         chk(errorLamp, 1);
         rdReg(`SLI_ADDR_FLAGS0 + 4'(c), got); chk(got[0], 1);
         wrReg(`SLI_ADDR_FLAGS0 + 4'(c), 16'h0001); chk({st[c].serialErr, errorLamp}, 0);
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         ev[1][3:0] <= 4'h1 << i;
         #1; chk(errorLamp, 1);
         pulse(1, '0); chk(errorLamp, 0);
      end
      pulse(0, 11'h100); chk(st[0].sendWait, 1);
      rdReg(`SLI_ADDR_LAMPS, got); chk(got[2], 1);
      pulse(0, 11'h080); chk(st[0].sendWait, 0);
      pulse(1, 11'h100); pulse(1, 11'h180); chk(st[1].sendWait, 0);
      for (int b = 1; b >= 0; b--) begin
         @(posedge clock);
         cpuBusy <= b[0];
         ev[0].txActive <= b[0];
         ev[1].rxActive <= b[0];
         hi = 0;
         repeat (16) begin
            waitc(1);
            hi += 16'(accessLamp + 4 * st[0].sendLamp + 16 * st[1].recvLamp);
         end
         chk(hi, b ? 16'hA8 : 16'h0);
      end
      @(posedge clock);
      periphReq <= 1;
      holdOff <= 1;
      wrReg(`SLI_ADDR_CTRL, 16'h0303); waitc(2);
      rdReg(`SLI_ADDR_CTRL, got); chk(got, 16'h0303);
      chk({periphSel, st[1].modemEn, txAllow}, 16'h000C);
      wrReg(`SLI_ADDR_CTRL, 16'h0300); chk(periphSel, 0);
      @(posedge clock);
      holdOff <= 0;
      waitc(2); chk(txAllow, 3);
      wrReg(`SLI_ADDR_CTRL, 16'h0000); chk({rts, txAllow}, 16'hF);
      for (int k = 0; k < 10; k++) begin
         wrReg(`SLI_ADDR_RATE, 16'(k)); waitc(2);
         chk({st[0].rateSel, rateError}, 16'(k * 2 + (k == 9)));
      end
      wrReg(`SLI_ADDR_RATE, 16'h0A03); waitc(2);
      chk({st[1].rateSel, st[0].rateSel, rateError}, 16'h06);
      final_report;
   end
endmodule

// [hdl/sli_consts.svh]
`ifndef SLI_CONSTS_SVH
`define SLI_CONSTS_SVH
`define SLI_ADDR_CTRL 4'h0
`define SLI_ADDR_RATE 4'h1
`define SLI_ADDR_FLAGS0 4'h2
`define SLI_ADDR_FLAGS1 4'h3
`define SLI_ADDR_LAMPS 4'h4
`define SLI_RATE_MAX_BPS 17'h1C200
`define SLI_BLINK_HALF_NS 100000000
`define SLI_CLOCK_NS 5
`define SLI_NUM_RATES 4'hC
`endif

// [hdl/sli_indicators.sv]
`include "sli_consts.svh"
module sli_indicators
   import sli_pkg::*;
#(
   parameter int BLINK_CYCLES = `SLI_BLINK_HALF_NS / `SLI_CLOCK_NS
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire sli_chev_s [1:0] chEvent,
   input wire logic cpuBusy,
   input wire logic [1:0] ctsIn,
   input wire logic periphReq,
   output sli_chst_s [1:0] chStat,
   output logic [1:0] txAllow,
   output logic [1:0] rtsOut,
   output logic periphSel,
   output logic rateError,
   output logic errorLamp,
   output logic accessLamp
);
   // Bit rate in bps for each rate selector code
   function automatic logic [16:0] rateBps(input logic [3:0] sel);
      logic [16:0] r;
      r = 17'h0;
      unique case (sel)
         4'h0: r = 17'h004B0; // 1200
         4'h1: r = 17'h00960;
         4'h2: r = 17'h012C0;
         4'h3: r = 17'h02580;
         4'h4: r = 17'h04B00;
         4'h5: r = 17'h09600; // 38400
         4'h6: r = 17'h03840; // 14400
         4'h7: r = 17'h07080; // 28800
         4'h8: r = 17'h0E100; // 57600
         4'h9: r = 17'h1C200; // 115200
         default: r = 17'h0;
      endcase
      return r;
   endfunction

   logic [3:0] ctrl [1:0];
   logic [3:0] rate [1:0];
   logic [31:0] blinkCnt;
   logic blink;
   logic [17:0] rateSum;

   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl[0] <= 4'h0;
         ctrl[1] <= 4'h0;
         rate[0] <= 4'h0;
         rate[1] <= 4'h0;
      end else if (wr) begin
         if (addr == `SLI_ADDR_CTRL) begin
            ctrl[0] <= wdata[3:0];
            ctrl[1] <= wdata[11:8];
         end
         if (addr == `SLI_ADDR_RATE) begin
            // Only the rate ladder codes are accepted
            if (wdata[3:0] < `SLI_NUM_RATES - 4'h2) rate[0] <= wdata[3:0];
            if (wdata[11:8] < `SLI_NUM_RATES - 4'h2) rate[1] <= wdata[11:8];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst || blinkCnt == BLINK_CYCLES - 1) blinkCnt <= 32'h0;
      else blinkCnt <= blinkCnt + 32'h1;
   end

   always_ff @(posedge clock) begin
      if (rst) blink <= 1'b0;
      else if (blinkCnt == BLINK_CYCLES - 1) blink <= ~blink;
   end

   assign rateSum = {1'b0, rateBps(rate[0])} + {1'b0, rateBps(rate[1])};
   // Flag an illegal combined rate chosen by software
   always_ff @(posedge clock) begin
      if (rst) rateError <= 1'b0;
      else rateError <= rateSum > {1'b0, `SLI_RATE_MAX_BPS};
   end

   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : gCh
         logic serialErr, sendWait, anyErr;
         always_ff @(posedge clock) begin
            // Hardware set wins over software clear
            if (rst) serialErr <= 1'b0;
            else if (chEvent[c].overrun || chEvent[c].framing || chEvent[c].rxDiscard)
               serialErr <= 1'b1;
            else if (wr && addr == `SLI_ADDR_FLAGS0 + 4'(c) && wdata[0]) serialErr <= 1'b0;
         end
         always_ff @(posedge clock) begin
            if (rst) sendWait <= 1'b0;
            else if (chEvent[c].txStart) sendWait <= 1'b0;
            else if (chEvent[c].sendPending) sendWait <= 1'b1;
         end
         always_comb begin
            chStat[c].sendLamp = chEvent[c].txActive & blink;
            chStat[c].recvLamp = chEvent[c].rxActive & blink;
            chStat[c].sendWait = sendWait;
            chStat[c].serialErr = serialErr;
            chStat[c].modemEn = ctrl[c][0];
            chStat[c].flowEn = ctrl[c][1];
            chStat[c].rateSel = rate[c];
            // With flow control on, sending waits for clear-to-send
            txAllow[c] = ~ctrl[c][1] | ctsIn[c];
            rtsOut[c] = ctrl[c][1] ? ~sendWait | chEvent[c].txActive : 1'b1;
            anyErr = serialErr | chEvent[c].chErr | chEvent[c].cpuErr | chEvent[c].parityErr
               | chEvent[c].protoErr;
         end
      end
   endgenerate

   assign errorLamp = gCh[0].anyErr | gCh[1].anyErr;
   assign accessLamp = cpuBusy & blink;
   // Programming peripheral only through the first channel in modem use
   assign periphSel = periphReq & ctrl[0][0];

   always_ff @(posedge clock) begin
      if (rst) rdata <= 16'h0;
      else if (rd) begin
         unique case (addr)
            `SLI_ADDR_CTRL: rdata <= {4'h0, ctrl[1], 4'h0, ctrl[0]};
            `SLI_ADDR_RATE: rdata <= {4'h0, rate[1], 4'h0, rate[0]};
            `SLI_ADDR_FLAGS0: rdata <= {15'h0, chStat[0].serialErr};
            `SLI_ADDR_FLAGS1: rdata <= {15'h0, chStat[1].serialErr};
            `SLI_ADDR_LAMPS: rdata <= {9'h0, rateError, accessLamp, errorLamp,
               chStat[1].sendWait, chStat[0].sendWait, 2'h0};
            default: rdata <= 16'h0;
         endcase
      end else rdata <= 16'h0;
   end

   a_serial_set: assert property (@(posedge clock) disable iff (rst)
      chEvent[0].overrun |=> chStat[0].serialErr) else $error("serial flag not set");
   a_wait_clear: assert property (@(posedge clock) disable iff (rst)
      chEvent[0].txStart |=> !chStat[0].sendWait) else $error("send wait stuck");
   a_wait_set: assert property (@(posedge clock) disable iff (rst)
      chEvent[1].sendPending && !chEvent[1].txStart |=> chStat[1].sendWait)
      else $error("send wait not set");
   a_error_sum: assert property (@(posedge clock) disable iff (rst)
      chEvent[1].protoErr |-> errorLamp) else $error("error lamp off");
   a_access_off: assert property (@(posedge clock) disable iff (rst)
      !cpuBusy |-> !accessLamp) else $error("access lamp on when idle");
   a_lamp_idle: assert property (@(posedge clock) disable iff (rst)
      !chEvent[0].txActive |-> !chStat[0].sendLamp) else $error("send lamp on when idle");
   a_flow_gate: assert property (@(posedge clock) disable iff (rst)
      chStat[0].flowEn && !ctsIn[0] |-> !txAllow[0]) else $error("cts ignored");
   a_periph_ch: assert property (@(posedge clock) disable iff (rst)
      periphSel |-> chStat[0].modemEn) else $error("peripheral off first channel");

   // Multi-step behaviours are composed from these sequences
   sequence s_wait_raised;
      chEvent[0].sendPending && !chEvent[0].txStart;
   endsequence
   sequence s_wait_quiet;
      !chEvent[0].sendPending && !chEvent[0].txStart;
   endsequence
   sequence s_serial_hit0;
      chEvent[0].overrun || chEvent[0].framing || chEvent[0].rxDiscard;
   endsequence
   sequence s_serial_hit1;
      chEvent[1].overrun || chEvent[1].framing || chEvent[1].rxDiscard;
   endsequence

   a_wait_holds: assert property (@(posedge clock) disable iff (rst)
      s_wait_raised ##1 s_wait_quiet |=> chStat[0].sendWait)
      else $error("send wait dropped early");
   a_wait_release: assert property (@(posedge clock) disable iff (rst)
      chEvent[1].txStart |=> !chStat[1].sendWait)
      else $error("send wait stuck on second channel");
   a_serial_any: assert property (@(posedge clock) disable iff (rst)
      s_serial_hit0 |=> chStat[0].serialErr)
      else $error("serial flag missed on first channel");
   a_serial_second: assert property (@(posedge clock) disable iff (rst)
      s_serial_hit1 |=> chStat[1].serialErr)
      else $error("serial flag missed on second channel");
   a_flag_clear: assert property (@(posedge clock) disable iff (rst)
      wr && addr == `SLI_ADDR_FLAGS0 && wdata[0] && !chEvent[0].overrun
      && !chEvent[0].framing && !chEvent[0].rxDiscard |=> !chStat[0].serialErr)
      else $error("serial flag not cleared");
   a_error_quiet: assert property (@(posedge clock) disable iff (rst)
      !chStat[0].serialErr && !chStat[1].serialErr && chEvent[0][3:0] == 4'h0
      && chEvent[1][3:0] == 4'h0 |-> !errorLamp)
      else $error("error lamp on without error");
   a_error_serial: assert property (@(posedge clock) disable iff (rst)
      chStat[1].serialErr |-> errorLamp)
      else $error("error lamp off with serial error");
   a_recv_idle: assert property (@(posedge clock) disable iff (rst)
      !chEvent[1].rxActive |-> !chStat[1].recvLamp)
      else $error("receive lamp on when idle");
   a_blink_phase: assert property (@(posedge clock) disable iff (rst)
      $changed(blink) |-> blinkCnt == 32'h0)
      else $error("blink toggled off its period");
   a_flow_off: assert property (@(posedge clock) disable iff (rst)
      !chStat[1].flowEn |-> txAllow[1] && rtsOut[1])
      else $error("flow control active while disabled");
   a_rts_hold: assert property (@(posedge clock) disable iff (rst)
      chStat[0].flowEn && chStat[0].sendWait && !chEvent[0].txActive |-> !rtsOut[0])
      else $error("request to send raised while waiting");
   a_rate_refuse: assert property (@(posedge clock) disable iff (rst)
      wr && addr == `SLI_ADDR_RATE && wdata[3:0] >= 4'hA |=> $stable(chStat[0].rateSel))
      else $error("illegal rate code accepted");
   a_modem_second: assert property (@(posedge clock) disable iff (rst)
      wr && addr == `SLI_ADDR_CTRL |=> chStat[1].modemEn == $past(wdata[8]))
      else $error("second channel modem enable not taken");
   a_periph_req: assert property (@(posedge clock) disable iff (rst)
      !periphReq |-> !periphSel)
      else $error("peripheral selected without request");
   a_rdata_idle: assert property (@(posedge clock) disable iff (rst)
      !rd |=> rdata == 16'h0000)
      else $error("read data outside read answer");
endmodule

// [hdl/sli_pkg.sv]
package sli_pkg;
   typedef struct packed {
      logic txActive;
      logic rxActive;
      logic sendPending;
      logic txStart;
      logic overrun;
      logic framing;
      logic rxDiscard;
      logic chErr;
      logic cpuErr;
      logic parityErr;
      logic protoErr;
   } sli_chev_s;
   typedef struct packed {
      logic sendLamp;
      logic recvLamp;
      logic sendWait;
      logic serialErr;
      logic modemEn;
      logic flowEn;
      logic [3:0] rateSel;
   } sli_chst_s;
endpackage
